// File: bench/periph_clock_gate_and_timer_input_select_properties.sv
`timescale 1ns/1ps

module periph_clock_gate_and_timer_input_select_properties (
	input wire logic CLK_SYS_IN, RSTN_IN, WR_IN, RD_IN,
	input wire logic [7:0] ADDR_IN, WDATA_IN, RDATA_OUT,
	input wire logic COMPARE_CHANNEL_ZERO_IN, COMPARE_CHANNEL_ONE_IN, COMPARE_CHANNEL_TWO_IN,
	input wire logic CC_TIMER_A_ZERO_MATCH_IN, CC_TIMER_A_PERIOD_MATCH_IN,
	input wire logic CC_TIMER_A_COMPARE_MATCH_ZERO_IN, CC_TIMER_A_COMPARE_MATCH_ONE_IN,
	input wire logic CC_TIMER_A_COMPARE_MATCH_TWO_IN,
	input wire logic CC_TIMER_B_PERIOD_MATCH_IN, CC_TIMER_B_ZERO_MATCH_IN,
	input wire logic TIMER3_INPUT_B_OUT, TIMER4_INPUT_D_OUT, CC_UNIT_IRQ_OUT,
	input wire logic GP_TIMER_GATE_REQ_OUT, TIMER_TWO_GATE_REQ_OUT, CC_UNIT_GATE_REQ_OUT,
	input wire logic SYNC_SERIAL_1_GATE_REQ_OUT, CONVERTER_GATE_REQ_OUT,
	input wire logic TIMER_THREE_GATE_REQ_OUT, TIMER_TWENTYONE_GATE_REQ_OUT,
	input wire logic SYNC_SERIAL_2_GATE_REQ_OUT
);
	logic [5:0] tin;
	logic [2:0] quiet;
	logic [15:0] src;
	logic lvl;

	// Shadow of the selector register, so the mux result can be predicted
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			tin <= 6'h00;
			quiet <= 3'h7;
		end else if (WR_IN && ADDR_IN == 8'h68) begin
			tin <= WDATA_IN[5:0];
			quiet <= 3'h0;
		end else if (quiet != 3'h7) begin
			quiet <= quiet + 3'h1;
		end
	end

	// Reserved codes pick a constant zero slot
	assign src = {6'h00, CC_TIMER_B_ZERO_MATCH_IN, CC_TIMER_B_PERIOD_MATCH_IN,
		CC_TIMER_A_COMPARE_MATCH_TWO_IN, CC_TIMER_A_COMPARE_MATCH_ONE_IN,
		CC_TIMER_A_COMPARE_MATCH_ZERO_IN, CC_TIMER_A_PERIOD_MATCH_IN,
		CC_TIMER_A_ZERO_MATCH_IN, COMPARE_CHANNEL_TWO_IN, COMPARE_CHANNEL_ONE_IN,
		COMPARE_CHANNEL_ZERO_IN};
	assign lvl = src[tin[3:0]];

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RSTN_IN);

	a_read_idle_zero: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_read_zero: assert property ($past(RD_IN) && !($past(ADDR_IN) inside
		{8'h60, 8'h64, 8'h68, 8'h6C}) |-> RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	a_reserved_one_zero: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h60 |->
		RDATA_OUT[7:5] == 3'h0)
		else $error("reserved bits of gate register one not zero");
	a_reserved_two_zero: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h64 |->
		(RDATA_OUT & 8'hD5) == 8'h00)
		else $error("reserved bits of gate register two not zero");
	a_gate_one_follow: assert property (WR_IN && ADDR_IN == 8'h60 |-> ##2
		{GP_TIMER_GATE_REQ_OUT, TIMER_TWO_GATE_REQ_OUT, CC_UNIT_GATE_REQ_OUT,
		SYNC_SERIAL_1_GATE_REQ_OUT, CONVERTER_GATE_REQ_OUT} == $past(WDATA_IN[4:0], 2))
		else $error("gate requests of register one wrong");
	a_gate_two_follow: assert property (WR_IN && ADDR_IN == 8'h64 |-> ##2
		{TIMER_THREE_GATE_REQ_OUT, TIMER_TWENTYONE_GATE_REQ_OUT, SYNC_SERIAL_2_GATE_REQ_OUT}
		== {$past(WDATA_IN[5], 2), $past(WDATA_IN[3], 2), $past(WDATA_IN[1], 2)})
		else $error("gate requests of register two wrong");
	a_timer_outs_equal: assert property (TIMER3_INPUT_B_OUT == TIMER4_INPUT_D_OUT)
		else $error("timer inputs differ");
	a_timer_mux_path: assert property (TIMER3_INPUT_B_OUT == $past(lvl))
		else $error("timer input not the selected source");
	a_irq_after_edge: assert property ($rose(TIMER3_INPUT_B_OUT) && tin[5] && quiet > 3'h2
		|=> CC_UNIT_IRQ_OUT)
		else $error("no trigger after selected edge");
	a_single_pulse: assert property (!tin[4] && quiet > 3'h2 && CC_UNIT_IRQ_OUT
		|=> !CC_UNIT_IRQ_OUT)
		else $error("trigger held without persist");
	a_persist_hold: assert property (tin[4] && tin[5] && quiet > 3'h2 && CC_UNIT_IRQ_OUT
		|=> CC_UNIT_IRQ_OUT)
		else $error("persistent trigger dropped");
endmodule : periph_clock_gate_and_timer_input_select_properties

bind periph_clock_gate_and_timer_input_select
	periph_clock_gate_and_timer_input_select_properties chk_inst (.*);

// File: bench/testbench.sv
`timescale 1ns/1ps

module testbench;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_s;
	logic CLK_SYS_IN, RSTN_IN, WR_IN, RD_IN, TIMER_THREE_TRIG_IN;
	logic [7:0] ADDR_IN, WDATA_IN, RDATA_OUT, v, e1, e2;
	logic [9:0] src;
	logic TIMER3_INPUT_B_OUT, TIMER4_INPUT_D_OUT, CC_UNIT_IRQ_OUT;
	logic GP_TIMER_GATE_REQ_OUT, TIMER_TWO_GATE_REQ_OUT, CC_UNIT_GATE_REQ_OUT;
	logic SYNC_SERIAL_1_GATE_REQ_OUT, CONVERTER_GATE_REQ_OUT, TIMER_THREE_GATE_REQ_OUT;
	logic TIMER_TWENTYONE_GATE_REQ_OUT, SYNC_SERIAL_2_GATE_REQ_OUT;
	int n_errors = 0;
	int check_count = 0;
	int hits;
	row_s rows[8] = '{'{8'h60, 8'hFF, 8'h1F}, '{8'h64, 8'hFF, 8'h2A}, '{8'h68, 8'hFF, 8'h3F},
		'{8'h70, 8'hFF, 8'h00}, '{8'h60, 8'h0A, 8'h0A}, '{8'h64, 8'h15, 8'h00},
		'{8'h64, 8'h08, 8'h08}, '{8'h68, 8'h00, 8'h00}};
	wire [7:0] gates = {GP_TIMER_GATE_REQ_OUT, TIMER_TWO_GATE_REQ_OUT, CC_UNIT_GATE_REQ_OUT,
		SYNC_SERIAL_1_GATE_REQ_OUT, CONVERTER_GATE_REQ_OUT, TIMER_THREE_GATE_REQ_OUT,
		TIMER_TWENTYONE_GATE_REQ_OUT, SYNC_SERIAL_2_GATE_REQ_OUT};

	periph_clock_gate_and_timer_input_select periph_clock_gate_and_timer_input_select_inst (
		.*, .COMPARE_CHANNEL_ZERO_IN(src[0]), .COMPARE_CHANNEL_ONE_IN(src[1]),
		.COMPARE_CHANNEL_TWO_IN(src[2]), .CC_TIMER_A_ZERO_MATCH_IN(src[3]),
		.CC_TIMER_A_PERIOD_MATCH_IN(src[4]), .CC_TIMER_A_COMPARE_MATCH_ZERO_IN(src[5]),
		.CC_TIMER_A_COMPARE_MATCH_ONE_IN(src[6]), .CC_TIMER_A_COMPARE_MATCH_TWO_IN(src[7]),
		.CC_TIMER_B_PERIOD_MATCH_IN(src[8]), .CC_TIMER_B_ZERO_MATCH_IN(src[9]));

	// 40 MHz system clock
	initial begin
		CLK_SYS_IN = 1'b0;
		forever #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
	end

	task automatic results;
		if (n_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_SYS_IN);
		ADDR_IN <= a;
		WDATA_IN <= d;
		WR_IN <= 1'b1;
		@(posedge CLK_SYS_IN);
		WR_IN <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLK_SYS_IN);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		@(posedge CLK_SYS_IN);
		RD_IN <= 1'b0;
		#1;
		d = RDATA_OUT;
	endtask : rd

	// Reset for ten cycles, then the registers at 60, 64 and 68 and every request must be clear
	task automatic reset_and_check;
		RSTN_IN <= 1'b0;
		repeat (10) @(posedge CLK_SYS_IN);
		RSTN_IN <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(8'h60 + 8'(4 * i), v);
			chk("reset value", 8'h00, v);
		end
		chk("gate requests after reset", 8'h00, gates);
	endtask : reset_and_check

	// Counts trigger cycles over a short window after the sources move
	task automatic count_irq;
		hits = 0;
		repeat (6) begin
			@(posedge CLK_SYS_IN);
			#1;
			hits += int'(CC_UNIT_IRQ_OUT);
		end
	endtask : count_irq

	initial begin
		{WR_IN, RD_IN, TIMER_THREE_TRIG_IN, ADDR_IN, WDATA_IN, src} = '0;
		e1 = 8'h00;
		e2 = 8'h00;
		reset_and_check();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			chk("readback", rows[i].r, v);
			if (rows[i].a == 8'h60) e1 = rows[i].r;
			if (rows[i].a == 8'h64) e2 = rows[i].r;
			chk("gate requests", {e1[4:0], e2[5], e2[3], e2[1]}, gates);
		end
		// Every code, reserved ones with all sources high to catch leaks
		for (int c = 0; c < 16; c++) begin
			wr(8'h68, 8'h20 | 8'(c));
			@(posedge CLK_SYS_IN);
			src <= (c < 10) ? 10'(1 << c) : 10'h3FF;
			@(posedge CLK_SYS_IN);
			#1;
			chk("timer input b", 8'(c < 10), 8'(TIMER3_INPUT_B_OUT));
			chk("timer input d", 8'(c < 10), 8'(TIMER4_INPUT_D_OUT));
			@(posedge CLK_SYS_IN);
			#1;
			chk("irq on edge", 8'(c < 10), 8'(CC_UNIT_IRQ_OUT));
			@(posedge CLK_SYS_IN);
			#1;
			chk("irq one shot", 8'h00, 8'(CC_UNIT_IRQ_OUT));
			@(posedge CLK_SYS_IN);
			src <= 10'h000;
			@(posedge CLK_SYS_IN);
		end
		// Persistent trigger outlives a short source pulse
		wr(8'h68, 8'h30);
		@(posedge CLK_SYS_IN);
		src <= 10'h001;
		@(posedge CLK_SYS_IN);
		src <= 10'h000;
		repeat (6) @(posedge CLK_SYS_IN);
		#1;
		chk("irq held", 8'h01, 8'(CC_UNIT_IRQ_OUT));
		wr(8'h68, 8'h20);
		repeat (3) @(posedge CLK_SYS_IN);
		#1;
		chk("irq released", 8'h00, 8'(CC_UNIT_IRQ_OUT));
		// Irq source bit clear: selection ignored, timer_three drives the trigger
		wr(8'h68, 8'h00);
		src <= 10'h001;
		count_irq();
		chk("irq from selection", 8'h00, 8'(hits));
		@(posedge CLK_SYS_IN);
		src <= 10'h000;
		TIMER_THREE_TRIG_IN <= 1'b1;
		count_irq();
		chk("irq from timer three", 8'h01, 8'(hits));
		@(posedge CLK_SYS_IN);
		TIMER_THREE_TRIG_IN <= 1'b0;
		// Reset in mid-run with requests still set
		reset_and_check();
		results();
	end

	// Cuts a hang short; the whole run needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge CLK_SYS_IN);
		n_errors++;
		results();
	end
endmodule : testbench

// File: hw/periph_clock_gate_and_timer_input_select.sv
// Behaviour
// - One selected source drives both timer inputs
// - Source code bits 3:0 pick the match signal
// - Irq source bit picks timer_three or selection
// - Persist bit zero gives single-measurement trigger
// - Persist bit one holds trigger across edges
// - Reserved bits read zero, writes ignored
// - Each gate bit drives one active-high request
// - Peripheral itself synchronises its clock removal
// - Cleared bit keeps peripheral clocked, reset zero
// - Register one bits 4..0 map five peripherals
// - Register two bits 5,3,1 map three peripherals
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module periph_clock_gate_and_timer_input_select (
	input wire logic CLK_SYS_IN,
	input wire logic RSTN_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	input wire logic COMPARE_CHANNEL_ZERO_IN,
	input wire logic COMPARE_CHANNEL_ONE_IN,
	input wire logic COMPARE_CHANNEL_TWO_IN,
	input wire logic CC_TIMER_A_ZERO_MATCH_IN,
	input wire logic CC_TIMER_A_PERIOD_MATCH_IN,
	input wire logic CC_TIMER_A_COMPARE_MATCH_ZERO_IN,
	input wire logic CC_TIMER_A_COMPARE_MATCH_ONE_IN,
	input wire logic CC_TIMER_A_COMPARE_MATCH_TWO_IN,
	input wire logic CC_TIMER_B_PERIOD_MATCH_IN,
	input wire logic CC_TIMER_B_ZERO_MATCH_IN,
	input wire logic TIMER_THREE_TRIG_IN,
	output logic TIMER3_INPUT_B_OUT,
	output logic TIMER4_INPUT_D_OUT,
	output logic CC_UNIT_IRQ_OUT,
	output logic GP_TIMER_GATE_REQ_OUT,
	output logic TIMER_TWO_GATE_REQ_OUT,
	output logic CC_UNIT_GATE_REQ_OUT,
	output logic SYNC_SERIAL_1_GATE_REQ_OUT,
	output logic CONVERTER_GATE_REQ_OUT,
	output logic TIMER_THREE_GATE_REQ_OUT,
	output logic TIMER_TWENTYONE_GATE_REQ_OUT,
	output logic SYNC_SERIAL_2_GATE_REQ_OUT
);

	// Register storage
	logic [7:0] periph_gate_ctrl_one;
	logic [7:0] periph_gate_ctrl_two;
	logic [7:0] timer_input_select_reg;

	// Decoded fields of the selector
	logic [3:0] input_source_code;
	logic trigger_persist_cfg;
	logic ccu_irq_source_sel;

	// Address decode
	logic hit_gate_one;
	logic hit_gate_two;
	logic hit_tin_sel;
	logic hit_status;
	logic wr_gate_one;
	logic wr_gate_two;
	logic wr_tin_sel;
	logic wr_status;

	// Source selection
	logic src_level;
	logic src_reserved;
	logic sel_change;

	// Trigger shaping
	logic sel_trig;
	logic sel_edge;
	logic t3_trig;
	logic t3_edge;
	logic next_irq;
	logic edge_seen;

	// Read path
	logic [7:0] read_value;
	logic [7:0] status_value;

	// Field extraction keeps the rest of the code free of bit positions
	assign input_source_code = timer_input_select_reg[
		scu_gate_sel_pkg::POS_SRC_CODE_HI:scu_gate_sel_pkg::POS_SRC_CODE_LO];
	assign trigger_persist_cfg = timer_input_select_reg[scu_gate_sel_pkg::POS_TRIG_PERSIST];
	assign ccu_irq_source_sel = timer_input_select_reg[scu_gate_sel_pkg::POS_IRQ_SRC_SEL];

	// Address decoding, one hit line per register
	always_comb begin
		hit_gate_one = 1'b0;
		hit_gate_two = 1'b0;
		hit_tin_sel = 1'b0;
		hit_status = 1'b0;
		if (ADDR_IN == scu_gate_sel_pkg::OFS_GATE_ONE) begin
			hit_gate_one = 1'b1;
		end else if (ADDR_IN == scu_gate_sel_pkg::OFS_GATE_TWO) begin
			hit_gate_two = 1'b1;
		end else if (ADDR_IN == scu_gate_sel_pkg::OFS_TIN_SEL) begin
			hit_tin_sel = 1'b1;
		end else if (ADDR_IN == scu_gate_sel_pkg::OFS_SEL_STATUS) begin
			hit_status = 1'b1;
		end
	end

	// Write strobes; writes to unmapped addresses simply fall away
	assign wr_gate_one = WR_IN & hit_gate_one;
	assign wr_gate_two = WR_IN & hit_gate_two;
	assign wr_tin_sel = WR_IN & hit_tin_sel;
	assign wr_status = WR_IN & hit_status;

	// First management register; reserved bits are masked on the way in
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			periph_gate_ctrl_one <= scu_gate_sel_pkg::RST_GATE_ONE;
		end else if (wr_gate_one) begin
			periph_gate_ctrl_one <= WDATA_IN & scu_gate_sel_pkg::MASK_GATE_ONE;
		end
	end

	// Second management register, only bits 5, 3 and 1 exist
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			periph_gate_ctrl_two <= scu_gate_sel_pkg::RST_GATE_TWO;
		end else if (wr_gate_two) begin
			periph_gate_ctrl_two <= WDATA_IN & scu_gate_sel_pkg::MASK_GATE_TWO;
		end
	end

	// Timer input selector, bits 7:6 never stored
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			timer_input_select_reg <= scu_gate_sel_pkg::RST_TIN_SEL;
		end else if (wr_tin_sel) begin
			timer_input_select_reg <= WDATA_IN & scu_gate_sel_pkg::MASK_TIN_SEL;
		end
	end

	// A write that alters the source code or the persist bit ends a held
	// trigger, so that a stale trigger is not carried to a new source
	assign sel_change = wr_tin_sel &&
		((WDATA_IN[scu_gate_sel_pkg::POS_SRC_CODE_HI:scu_gate_sel_pkg::POS_SRC_CODE_LO]
		!= input_source_code) ||
		(WDATA_IN[scu_gate_sel_pkg::POS_TRIG_PERSIST] != trigger_persist_cfg));

	// Source multiplexer for the capture/compare match signals.
	// The match inputs come from logic on this same clock, so no
	// synchroniser is placed here; a source from another domain would
	// need one before it reaches this multiplexer.
	// Reserved codes are flagged so that software can see in the status
	// word why the timer inputs have gone quiet.
	always_comb begin
		src_level = 1'b0;
		src_reserved = 1'b0;
		case (input_source_code)
			scu_gate_sel_pkg::SRC_CMP_CH_ZERO: begin
				src_level = COMPARE_CHANNEL_ZERO_IN;
			end
			scu_gate_sel_pkg::SRC_CMP_CH_ONE: begin
				src_level = COMPARE_CHANNEL_ONE_IN;
			end
			scu_gate_sel_pkg::SRC_CMP_CH_TWO: begin
				src_level = COMPARE_CHANNEL_TWO_IN;
			end
			scu_gate_sel_pkg::SRC_TMR_A_ZERO_MATCH: begin
				src_level = CC_TIMER_A_ZERO_MATCH_IN;
			end
			scu_gate_sel_pkg::SRC_TMR_A_PERIOD_MATCH: begin
				src_level = CC_TIMER_A_PERIOD_MATCH_IN;
			end
			scu_gate_sel_pkg::SRC_TMR_A_CMP_MATCH_ZERO: begin
				src_level = CC_TIMER_A_COMPARE_MATCH_ZERO_IN;
			end
			scu_gate_sel_pkg::SRC_TMR_A_CMP_MATCH_ONE: begin
				src_level = CC_TIMER_A_COMPARE_MATCH_ONE_IN;
			end
			scu_gate_sel_pkg::SRC_TMR_A_CMP_MATCH_TWO: begin
				src_level = CC_TIMER_A_COMPARE_MATCH_TWO_IN;
			end
			scu_gate_sel_pkg::SRC_TMR_B_PERIOD_MATCH: begin
				src_level = CC_TIMER_B_PERIOD_MATCH_IN;
			end
			scu_gate_sel_pkg::SRC_TMR_B_ZERO_MATCH: begin
				src_level = CC_TIMER_B_ZERO_MATCH_IN;
			end
			default: begin
				// Held low so that a bad code cannot make edges
				src_level = 1'b0;
				src_reserved = 1'b1;
			end
		endcase
	end

	// Both timer inputs come from the same flop stage so they never skew
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			TIMER3_INPUT_B_OUT <= 1'b0;
			TIMER4_INPUT_D_OUT <= 1'b0;
		end else begin
			TIMER3_INPUT_B_OUT <= src_level;
			TIMER4_INPUT_D_OUT <= src_level;
		end
	end

	// Trigger from the selected source, single shot or held
	trigger_shaper sel_shaper (
		.clk_in(CLK_SYS_IN),
		.rstn_in(RSTN_IN),
		.level_in(src_level),
		.persist_in(trigger_persist_cfg),
		.clear_in(sel_change),
		.trig_out(sel_trig),
		.edge_out(sel_edge)
	);

	// Trigger from timer_three is always a single measurement.
	// The persist setting only applies to the selected source, so a held
	// level can never come from this path.
	trigger_shaper t3_shaper (
		.clk_in(CLK_SYS_IN),
		.rstn_in(RSTN_IN),
		.level_in(TIMER_THREE_TRIG_IN),
		.persist_in(1'b0),
		.clear_in(1'b0),
		.trig_out(t3_trig),
		.edge_out(t3_edge)
	);

	// Interrupt trigger source choice
	always_comb begin
		if (ccu_irq_source_sel) begin
			next_irq = sel_trig;
		end else begin
			next_irq = t3_trig;
		end
	end

	// Registered so the capture/compare unit sees a clean level
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			CC_UNIT_IRQ_OUT <= 1'b0;
		end else begin
			CC_UNIT_IRQ_OUT <= next_irq;
		end
	end

	// Sticky note of a selected-source edge; write one clears, edge wins
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			edge_seen <= 1'b0;
		end else if (sel_edge) begin
			edge_seen <= 1'b1;
		end else if (wr_status && WDATA_IN[scu_gate_sel_pkg::POS_ST_EDGE_SEEN]) begin
			edge_seen <= 1'b0;
		end
	end

	// Gate requests follow the register bits one cycle after the write.
	// No clock is stopped here: each peripheral finishes its own work and
	// then synchronises the gating, which avoids truncated clock pulses.
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			GP_TIMER_GATE_REQ_OUT <= 1'b0;
			TIMER_TWO_GATE_REQ_OUT <= 1'b0;
			CC_UNIT_GATE_REQ_OUT <= 1'b0;
			SYNC_SERIAL_1_GATE_REQ_OUT <= 1'b0;
			CONVERTER_GATE_REQ_OUT <= 1'b0;
		end else begin
			GP_TIMER_GATE_REQ_OUT <=
				periph_gate_ctrl_one[scu_gate_sel_pkg::POS_GP_TIMER_DIS];
			TIMER_TWO_GATE_REQ_OUT <=
				periph_gate_ctrl_one[scu_gate_sel_pkg::POS_TIMER_TWO_DIS];
			CC_UNIT_GATE_REQ_OUT <=
				periph_gate_ctrl_one[scu_gate_sel_pkg::POS_CC_UNIT_DIS];
			SYNC_SERIAL_1_GATE_REQ_OUT <=
				periph_gate_ctrl_one[scu_gate_sel_pkg::POS_SYNC_SERIAL_1_DIS];
			CONVERTER_GATE_REQ_OUT <=
				periph_gate_ctrl_one[scu_gate_sel_pkg::POS_CONVERTER_DIS];
		end
	end

	// Second group of gate requests, same timing as the first
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			TIMER_THREE_GATE_REQ_OUT <= 1'b0;
			TIMER_TWENTYONE_GATE_REQ_OUT <= 1'b0;
			SYNC_SERIAL_2_GATE_REQ_OUT <= 1'b0;
		end else begin
			TIMER_THREE_GATE_REQ_OUT <=
				periph_gate_ctrl_two[scu_gate_sel_pkg::POS_TIMER_THREE_DIS];
			TIMER_TWENTYONE_GATE_REQ_OUT <=
				periph_gate_ctrl_two[scu_gate_sel_pkg::POS_TIMER_TWENTYONE_DIS];
			SYNC_SERIAL_2_GATE_REQ_OUT <=
				periph_gate_ctrl_two[scu_gate_sel_pkg::POS_SYNC_SERIAL_2_DIS];
		end
	end

	// Status word showing the selector's live state
	always_comb begin
		status_value = 8'h00;
		status_value[scu_gate_sel_pkg::POS_ST_TRIG] = sel_trig;
		status_value[scu_gate_sel_pkg::POS_ST_RESERVED] = src_reserved;
		status_value[scu_gate_sel_pkg::POS_ST_SRC_LEVEL] = TIMER3_INPUT_B_OUT;
		status_value[scu_gate_sel_pkg::POS_ST_IRQ] = CC_UNIT_IRQ_OUT;
		status_value[scu_gate_sel_pkg::POS_ST_EDGE_SEEN] = edge_seen;
	end

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		read_value = 8'h00;
		if (hit_gate_one) begin
			read_value = periph_gate_ctrl_one;
		end else if (hit_gate_two) begin
			read_value = periph_gate_ctrl_two;
		end else if (hit_tin_sel) begin
			read_value = timer_input_select_reg;
		end else if (hit_status) begin
			read_value = status_value;
		end
	end

	// Read data stand only in the cycle after the strobe, zero otherwise.
	// Returning zero between reads costs a flop of gating but keeps the
	// bus quiet, so a master that samples late sees zero rather than a
	// stale value from an earlier read.
	// Status reads have no side effects; the sticky bit is cleared only
	// by an explicit write of one.
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			RDATA_OUT <= 8'h00;
		end else if (RD_IN) begin
			RDATA_OUT <= read_value;
		end else begin
			RDATA_OUT <= 8'h00;
		end
	end

endmodule : periph_clock_gate_and_timer_input_select

// File: hw/scu_gate_sel_pkg.sv
package scu_gate_sel_pkg;

	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Byte offsets of the registers
	localparam logic [7:0] OFS_GATE_ONE = 8'h60;
	localparam logic [7:0] OFS_GATE_TWO = 8'h64;
	localparam logic [7:0] OFS_TIN_SEL = 8'h68;
	localparam logic [7:0] OFS_SEL_STATUS = 8'h6C;

	// Reset values
	localparam logic [7:0] RST_GATE_ONE = 8'h00;
	localparam logic [7:0] RST_GATE_TWO = 8'h00;
	localparam logic [7:0] RST_TIN_SEL = 8'h00;

	// Writable bit masks; every other bit is reserved and reads zero
	localparam logic [7:0] MASK_GATE_ONE = 8'h1F;
	localparam logic [7:0] MASK_GATE_TWO = 8'h2A;
	localparam logic [7:0] MASK_TIN_SEL = 8'h3F;

	// Field positions in periph_gate_ctrl_one
	localparam int POS_GP_TIMER_DIS = 4;
	localparam int POS_TIMER_TWO_DIS = 3;
	localparam int POS_CC_UNIT_DIS = 2;
	localparam int POS_SYNC_SERIAL_1_DIS = 1;
	localparam int POS_CONVERTER_DIS = 0;

	// Field positions in periph_gate_ctrl_two
	localparam int POS_TIMER_THREE_DIS = 5;
	localparam int POS_TIMER_TWENTYONE_DIS = 3;
	localparam int POS_SYNC_SERIAL_2_DIS = 1;

	// Field positions in timer_input_source_select
	localparam int POS_IRQ_SRC_SEL = 5;
	localparam int POS_TRIG_PERSIST = 4;
	localparam int POS_SRC_CODE_HI = 3;
	localparam int POS_SRC_CODE_LO = 0;

	// Field positions in the selector status register
	localparam int POS_ST_TRIG = 0;
	localparam int POS_ST_RESERVED = 1;
	localparam int POS_ST_SRC_LEVEL = 2;
	localparam int POS_ST_IRQ = 3;
	localparam int POS_ST_EDGE_SEEN = 4;

	// Input source codes
	localparam logic [3:0] SRC_CMP_CH_ZERO = 4'h0;
	localparam logic [3:0] SRC_CMP_CH_ONE = 4'h1;
	localparam logic [3:0] SRC_CMP_CH_TWO = 4'h2;
	localparam logic [3:0] SRC_TMR_A_ZERO_MATCH = 4'h3;
	localparam logic [3:0] SRC_TMR_A_PERIOD_MATCH = 4'h4;
	localparam logic [3:0] SRC_TMR_A_CMP_MATCH_ZERO = 4'h5;
	localparam logic [3:0] SRC_TMR_A_CMP_MATCH_ONE = 4'h6;
	localparam logic [3:0] SRC_TMR_A_CMP_MATCH_TWO = 4'h7;
	localparam logic [3:0] SRC_TMR_B_PERIOD_MATCH = 4'h8;
	localparam logic [3:0] SRC_TMR_B_ZERO_MATCH = 4'h9;

endpackage : scu_gate_sel_pkg

// File: hw/trigger_shaper.sv
`timescale 1ns/1ps

// Turns a source level into a measurement trigger: a one-cycle pulse per
// rising edge, or a level that is held once the first edge has arrived.
module trigger_shaper (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic level_in,
	input wire logic persist_in,
	input wire logic clear_in,
	output logic trig_out,
	output logic edge_out
);

	logic prev;

	// Previous level for rising edge detection
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prev <= 1'b0;
		end else begin
			prev <= level_in;
		end
	end

	assign edge_out = level_in & ~prev;

	// An edge wins over a clear so that no trigger is lost on reconfiguration
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			trig_out <= 1'b0;
		end else if (edge_out) begin
			trig_out <= 1'b1;
		end else if (clear_in || !persist_in) begin
			trig_out <= 1'b0;
		end
	end

endmodule : trigger_shaper
